/* File: rtl/fdcr_defs.vh */
// Constants for the floppy controller host register bank.
// Assumes inclusion by fdcr_regs.v only.
`ifndef FDCR_DEFS_VH
`define FDCR_DEFS_VH
// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define FDCR_IDX_STA      3'h0
`define FDCR_IDX_STB      3'h1
`define FDCR_IDX_DOC      3'h2
`define FDCR_IDX_TAPE     3'h3
`define FDCR_IDX_RATE     3'h4
`define FDCR_IDX_FIFO     3'h5
`define FDCR_IDX_CCTL     3'h7
`define FDCR_ADDR_CFG     5'h18
// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define FDCR_RATE_SWRST   7
`define FDCR_RATE_PDOWN   6
`define FDCR_DOC_DMAEN    3
`define FDCR_CMD_LOCK     7'h14
`define FDCR_CMD_SENSE    8'h04
`define FDCR_CMD_CONFIG   8'h13
`define FDCR_ST0_INVALID  8'h80
`define FDCR_MS_RQM       8'h80
`define FDCR_MS_DIO       8'h40
`define FDCR_MS_BUSY      8'h10
`define FDCR_PRE_OFF      3'h7
`define FDCR_PRE_STEP_PS  41670
`define FDCR_PRE_TAPE_PS  20800
`define FDCR_RATE_RST     2'h2
`define FDCR_RESP_OKAY    2'h0
`define FDCR_RESP_SLVERR  2'h2
`endif

/* File: rtl/fdcr_regs.v */
// Host register bank of a floppy disk controller behind an AXI4-Lite slave.
// Assumes drive pins are synchronous to aclk; one read and one write at a time.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fdcr_defs.vh"

// Behaviour
// R1: lock command echoes lock flag at D4
// R2: sense drive status returns status three
// R3: undefined command gives 80h, goes standby
// R4: offsets 0,1 read, 2 write, 3 both
// R5: offsets 4, 5, 7 split by direction
// R6: mode one status A bits 7..4
// R7: mode one status A bits 3..0
// R8: mode two status A bits 7..4
// R9: mode two status A bits 3..0
// R10: mode one status B data toggles
// R11: mode one status B select, gate, motors
// R12: mode two status B drive, selects
// R13: mode two status B latched inverted copies
// R14: output register write-only, master reset clears
// R15: tape register two bits unless three-mode
// R16: three-mode media and boot bits mirrored
// R17: drive-type pair chosen by last select
// R18: tape select maps logical drive 1..3
// R19: rate follows latest rate or control write
// R20: rate bit 7 issues software reset
// R21: rate bit 6 selects power-down
// R22: rate bits 4..2 set precompensation
// R23: rate code sets reduced write current
// R24: FIFO disabled after reset, configure enables
// R25: software reset bit clears itself
module fdcr_regs #(
  parameter FIFO_THR_W = 4
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        master_reset_in,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        compat_mode_two,
  input  wire        three_speed_enable,
  input  wire [7:0]  cfg_reg_f1,
  input  wire [7:0]  cfg_reg_f2,
  input  wire        disk_irq,
  input  wire        dma_req,
  input  wire        second_unit_absent,
  input  wire        step_n,
  input  wire        track_zero_in,
  input  wire        head_n,
  input  wire        index_in,
  input  wire        write_protect_n,
  input  wire        dir_in,
  input  wire        write_data_out,
  input  wire        read_data_in,
  input  wire        write_gate_n,
  input  wire        motor_a_out,
  input  wire        motor_b_out,
  input  wire        unit_a_select_out,
  input  wire        unit_b_select_out,
  input  wire        unit_c_select,
  input  wire        unit_d_select,
  output reg  [7:0]  drive_output_control,
  output reg         soft_reset,
  output reg         power_down,
  output reg  [2:0]  write_shift_delay,
  output reg         precomp_off,
  output reg  [1:0]  rate_code,
  output reg         reduced_write_current,
  output reg         fifo_enable,
  output reg  [FIFO_THR_W-1:0] fifo_threshold,
  output reg         standby,
  output reg         lock_flag
);

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  reg        aw_hold_reg;
  reg  [4:0] aw_addr_reg;
  reg        w_hold_reg;
  reg  [7:0] w_data_reg;
  reg        w_lane_reg;
  wire       wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire [2:0] wr_idx = aw_addr_reg[4:2];
  wire       wr_lo = (aw_addr_reg[4:2] != 3'h6) & w_lane_reg;

  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready  = ~w_hold_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      aw_addr_reg  <= 5'h00;
      w_hold_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FDCR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg[4:2] == 3'h6) ? `FDCR_RESP_SLVERR : `FDCR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin edge trackers
  // ----------------------------------------------------------------
  reg wd_prev_reg;
  reg rd_prev_reg;
  reg wd_tog_reg;
  reg rd_tog_reg;
  reg wd_ff_reg;
  reg rd_ff_reg;
  reg we_ff_reg;
  reg step_ff_reg;
  wire wd_rise = write_data_out & ~wd_prev_reg;
  wire rd_rise = read_data_in & ~rd_prev_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      wd_tog_reg  <= 1'b0;
      rd_tog_reg  <= 1'b0;
      wd_ff_reg   <= 1'b0;
      rd_ff_reg   <= 1'b0;
      we_ff_reg   <= 1'b0;
      step_ff_reg <= 1'b0;
    end else begin
      wd_prev_reg <= write_data_out;
      rd_prev_reg <= read_data_in;
      // R10 toggle on rising edges
      if (wd_rise)
        wd_tog_reg <= ~wd_tog_reg;
      if (rd_rise)
        rd_tog_reg <= ~rd_tog_reg;
      // R13 latched on write data and read data rising edges
      if (wd_rise)
        wd_ff_reg <= ~write_data_out;
      if (rd_rise)
        rd_ff_reg <= ~read_data_in;
      // Latch is set by an active gate or step
      if (!write_gate_n)
        we_ff_reg <= 1'b1;
      else if (wd_rise)
        we_ff_reg <= 1'b0;
      if (!step_n)
        step_ff_reg <= 1'b1;
      else if (wr_go && wr_lo && wr_idx == `FDCR_IDX_DOC)
        step_ff_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and command bytes
  // ----------------------------------------------------------------
  reg  [1:0] tape_sel_reg;
  reg  [1:0] last_drive_reg;
  reg  [7:0] result_reg;
  reg        result_valid_reg;
  reg  [1:0] cmd_state_reg;
  reg  [7:0] cmd_byte_reg;
  reg        precomp_bit_reg;

  localparam ST_IDLE   = 2'h0;
  localparam ST_SENSE  = 2'h1;
  localparam ST_CFG1   = 2'h2;
  localparam ST_CFG2   = 2'h3;

  function [7:0] st3_byte;
    input [2:0] sel;
    begin
      st3_byte = {1'b0, ~write_protect_n, 1'b1, ~track_zero_in, 1'b1, sel};
    end
  endfunction

  wire fifo_wr = wr_go && wr_lo && wr_idx == `FDCR_IDX_FIFO;
  wire       rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire       rd_fifo_go = rd_go && s_axi_araddr[4:2] == `FDCR_IDX_FIFO;

  always @(posedge aclk) begin
    if (!aresetn || master_reset_in) begin
      // R14 master reset clears
      drive_output_control  <= 8'h00;
      tape_sel_reg          <= 2'h0;
      last_drive_reg        <= 2'h0;
      soft_reset            <= 1'b0;
      power_down            <= 1'b0;
      write_shift_delay     <= 3'h0;
      precomp_off           <= 1'b0;
      rate_code             <= `FDCR_RATE_RST;
      reduced_write_current <= 1'b0;
      // R24 FIFO off after reset
      fifo_enable           <= 1'b0;
      fifo_threshold        <= {FIFO_THR_W{1'b0}};
      standby               <= 1'b0;
      lock_flag             <= 1'b0;
      result_reg            <= 8'h00;
      result_valid_reg      <= 1'b0;
      cmd_state_reg         <= ST_IDLE;
      cmd_byte_reg          <= 8'h00;
      precomp_bit_reg       <= 1'b0;
    end else begin
      // R25 reset pulse self-clears
      soft_reset <= 1'b0;
      // Read clears the pending result; a new result in the same cycle wins
      if (rd_fifo_go)
        result_valid_reg <= 1'b0;
      if (wr_go && wr_lo) begin
        case (wr_idx)
          // R4 output register write
          `FDCR_IDX_DOC: begin
            drive_output_control <= w_data_reg;
            last_drive_reg       <= w_data_reg[1:0];
          end
          // R18 tape drive assignment
          `FDCR_IDX_TAPE: tape_sel_reg <= w_data_reg[1:0];
          `FDCR_IDX_RATE: begin
            // R20 software reset
            soft_reset        <= w_data_reg[`FDCR_RATE_SWRST];
            // R21 power-down control
            power_down        <= w_data_reg[`FDCR_RATE_PDOWN];
            // R22 precompensation code
            write_shift_delay <= w_data_reg[4:2];
            precomp_off       <= (w_data_reg[4:2] == `FDCR_PRE_OFF);
            // R19 latest write sets rate
            rate_code         <= w_data_reg[1:0];
            // R23 reduced write current
            reduced_write_current <= (w_data_reg[1] == w_data_reg[0]);
          end
          `FDCR_IDX_CCTL: begin
            // R19 latest write sets rate
            rate_code       <= w_data_reg[1:0];
            reduced_write_current <= (w_data_reg[1] == w_data_reg[0]);
            precomp_bit_reg <= w_data_reg[2];
          end
          default: ;
        endcase
      end
      if (fifo_wr) begin
        standby <= 1'b0;
        case (cmd_state_reg)
          ST_IDLE: begin
            if (w_data_reg[6:0] == `FDCR_CMD_LOCK) begin
              // R1 lock answer at D4
              lock_flag        <= w_data_reg[7];
              result_reg       <= {3'h0, w_data_reg[7], 4'h0};
              result_valid_reg <= 1'b1;
            end else if (w_data_reg == `FDCR_CMD_SENSE) begin
              cmd_state_reg <= ST_SENSE;
            end else if (w_data_reg == `FDCR_CMD_CONFIG) begin
              cmd_state_reg <= ST_CFG1;
            end else begin
              // R3 invalid code result
              standby          <= 1'b1;
              result_reg       <= `FDCR_ST0_INVALID;
              result_valid_reg <= 1'b1;
            end
          end
          ST_SENSE: begin
            // R2 status three result
            result_reg       <= st3_byte(w_data_reg[2:0]);
            result_valid_reg <= 1'b1;
            cmd_state_reg    <= ST_IDLE;
          end
          ST_CFG1: cmd_state_reg <= ST_CFG2;
          ST_CFG2: begin
            // R24 configure enables FIFO
            fifo_enable    <= ~w_data_reg[5];
            fifo_threshold <= w_data_reg[FIFO_THR_W-1:0];
            cmd_state_reg  <= ST_IDLE;
          end
          default: cmd_state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and AXI read channel
  // ----------------------------------------------------------------
  reg  [7:0] rd_byte;
  reg  [1:0] rd_resp;
  wire [1:0] dt_pair = (last_drive_reg == 2'h0) ? cfg_reg_f2[1:0] :
                       (last_drive_reg == 2'h1) ? cfg_reg_f2[3:2] :
                       (last_drive_reg == 2'h2) ? cfg_reg_f2[5:4] : cfg_reg_f2[7:6];

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_byte = 8'h00;
    rd_resp = `FDCR_RESP_OKAY;
    case (s_axi_araddr[4:2])
      `FDCR_IDX_STA: begin
        if (!compat_mode_two)
          // R6 R7 mode one status A
          rd_byte = {disk_irq, second_unit_absent, ~step_n, track_zero_in,
                     ~head_n, index_in, write_protect_n, dir_in};
        else
          // R8 R9 mode two status A
          rd_byte = {disk_irq, dma_req, ~step_ff_reg, ~track_zero_in,
                     head_n, ~index_in, ~write_protect_n, ~dir_in};
      end
      `FDCR_IDX_STB: begin
        if (!compat_mode_two)
          // R10 R11 mode one status B
          rd_byte = {2'h3, drive_output_control[0], wd_tog_reg, rd_tog_reg,
                     ~write_gate_n, ~motor_b_out, ~motor_a_out};
        else
          // R12 R13 mode two status B
          rd_byte = {second_unit_absent, unit_b_select_out, unit_a_select_out,
                     wd_ff_reg, rd_ff_reg, ~we_ff_reg, unit_d_select, unit_c_select};
      end
      `FDCR_IDX_TAPE: begin
        // R15 R16 R17 tape register view
        if (three_speed_enable)
          rd_byte = {cfg_reg_f1[4], cfg_reg_f1[5], dt_pair,
                     cfg_reg_f1[7], cfg_reg_f1[6], tape_sel_reg};
        else
          rd_byte = {6'h00, tape_sel_reg};
      end
      // R5 main status on read
      `FDCR_IDX_RATE: rd_byte = `FDCR_MS_RQM |
                                (result_valid_reg ? (`FDCR_MS_DIO | `FDCR_MS_BUSY) : 8'h00);
      `FDCR_IDX_FIFO: rd_byte = result_reg;
      `FDCR_IDX_CCTL: rd_byte = {1'b0, 3'h7, drive_output_control[`FDCR_DOC_DMAEN],
                                 precomp_bit_reg, rate_code};
      default: begin
        if (s_axi_araddr == `FDCR_ADDR_CFG)
          rd_byte = {standby, lock_flag, fifo_enable, power_down, 4'h0};
        else
          rd_resp = `FDCR_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FDCR_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // fdcr_regs
`default_nettype wire

/* File: dv/fdcr_regs_asserts.sv */
// Concurrent checks on the floppy register bank ports.
// Assumes a bind onto fdcr_regs; a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module fdcr_regs_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        master_reset_in,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [7:0]  drive_output_control,
  input wire logic        soft_reset,
  input wire logic [2:0]  write_shift_delay,
  input wire logic        precomp_off,
  input wire logic [1:0]  rate_code,
  input wire logic        reduced_write_current,
  input wire logic        fifo_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------
  // Port relations
  // --------------------
  property p_rst_defaults;
    $rose(aresetn) |-> !fifo_enable && rate_code == 2'h2;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults)
    else $error("fifo or rate not at reset value");
  property p_swrst_pulse;
    soft_reset |=> !soft_reset;
  endproperty
  a_swrst_pulse: assert property (p_swrst_pulse)
    else $error("software reset longer than one cycle");
  property p_mr_clear;
    master_reset_in |=> drive_output_control == 8'h00;
  endproperty
  a_mr_clear: assert property (p_mr_clear)
    else $error("output register not cleared");
  property p_rwc;
    reduced_write_current == (rate_code[1] == rate_code[0]);
  endproperty
  a_rwc: assert property (p_rwc)
    else $error("reduced write current wrong for rate");
  property p_precomp_off;
    precomp_off == (write_shift_delay == 3'h7);
  endproperty
  a_precomp_off: assert property (p_precomp_off)
    else $error("precompensation disable wrong");
  property p_rvalid_after_ar;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rvalid_after_ar: assert property (p_rvalid_after_ar)
    else $error("read answer late");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read answer dropped or changed");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write answer dropped or changed");
endmodule // fdcr_regs_asserts
`default_nettype wire

/* File: dv/fdcr_drive_model.sv */
// Far-side model: drive and controller pin levels.
// Assumes the bench sets pin_set between register accesses.
`timescale 1ns/1ps
`default_nettype none
module fdcr_drive_model (
  input  wire logic [17:0] pin_set,
  output logic             disk_irq,
  output logic             dma_req,
  output logic             second_unit_absent,
  output logic             step_n,
  output logic             track_zero_in,
  output logic             head_n,
  output logic             index_in,
  output logic             write_protect_n,
  output logic             dir_in,
  output logic             write_data_out,
  output logic             read_data_in,
  output logic             write_gate_n,
  output logic             motor_a_out,
  output logic             motor_b_out,
  output logic             unit_a_select_out,
  output logic             unit_b_select_out,
  output logic             unit_c_select,
  output logic             unit_d_select
);
  assign {disk_irq, dma_req, second_unit_absent, step_n, track_zero_in, head_n, index_in,
          write_protect_n, dir_in, write_data_out, read_data_in, write_gate_n, motor_a_out,
          motor_b_out, unit_a_select_out, unit_b_select_out, unit_c_select,
          unit_d_select} = pin_set;
endmodule // fdcr_drive_model
`default_nettype wire

/* File: dv/fdcr_regs_test.sv */
// Self-checking bench for the floppy register bank over AXI4-Lite.
// Assumes fdcr_regs, fdcr_drive_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fdcr_regs_test;
  logic        aclk, aresetn, master_reset_in, compat_mode_two, three_speed_enable;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  cfg_reg_f1, cfg_reg_f2;
  logic [17:0] pin_set, pv;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, rate_code;
  wire  [31:0] s_axi_rdata;
  wire         disk_irq, dma_req, second_unit_absent, step_n, track_zero_in, head_n, index_in;
  wire         write_protect_n, dir_in, write_data_out, read_data_in, write_gate_n;
  wire         motor_a_out, motor_b_out, unit_a_select_out, unit_b_select_out;
  wire         unit_c_select, unit_d_select, soft_reset, power_down, precomp_off;
  wire         reduced_write_current, fifo_enable, standby, lock_flag;
  wire  [7:0]  drive_output_control;
  wire  [2:0]  write_shift_delay;
  wire  [3:0]  fifo_threshold;
  int          fail_count, cmp_count, swrst_seen;
  localparam logic [7:0]  TG_PIN = 8'b10110010;
  localparam logic [7:0]  TG_EXP = 8'b10111101;
  localparam logic [19:0] RT_A = {5'h10, 5'h1C, 5'h10, 5'h10};
  localparam logic [31:0] RT_D = {8'h5F, 8'h01, 8'h04, 8'h1A};
  localparam logic [31:0] RT_E = {8'hFF, 8'hFA, 8'h11, 8'h64};

  fdcr_regs #(.FIFO_THR_W(4)) uut (.*);
  fdcr_drive_model u_drv (.*);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) if (soft_reset === 1'b1) swrst_seen++;
  // --------------------
  // Tasks
  // --------------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
    bit da = 1'b0;
    bit dw = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) da = 1'b1;
      if (s_axi_wvalid && s_axi_wready) dw = 1'b1;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [4:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    axi_rd(a);
    check(n, rd & {24'h000000, m}, {24'h000000, e});
  endtask
  task automatic pins(input logic [17:0] v);
    pin_set <= v;
    repeat (4) @(posedge aclk);
  endtask
  function automatic logic [7:0] exp_sta(input logic m, input logic [17:0] p);
    if (m) return {p[17], p[16], 1'b0, ~p[13], p[12], ~p[11], ~p[10], ~p[9]};
    return {p[17], p[15], ~p[14], p[13], ~p[12], p[11], p[10], p[9]};
  endfunction
  function automatic logic [7:0] exp_stb(input logic m, input logic [17:0] p);
    if (m) return {p[15], p[2], p[3], 2'b00, p[6], p[0], p[1]};
    return {2'b11, 3'b000, ~p[6], ~p[4], ~p[5]};
  endfunction
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  initial begin
    {aresetn, master_reset_in, compat_mode_two, three_speed_enable} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 46'h0;
    cfg_reg_f1 = 8'h00;
    cfg_reg_f2 = 8'hE4;
    pin_set = 18'h00000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("fifo_after_reset", {31'h0, fifo_enable}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pins({9'h000, TG_PIN[7-2*i -: 2], 7'h00});
      rdchk("data_toggles", 5'h04, 8'h18, {3'b000, TG_EXP[7-2*i -: 2], 3'b000});
    end
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        pv = k ? 18'h15555 : 18'h2AAAA;
        compat_mode_two <= m[0];
        pins(pv);
        rdchk("status_a", 5'h00, 8'hFF, exp_sta(m[0], pv));
        rdchk("status_b", 5'h04, m ? 8'hFF : 8'hE7, exp_stb(m[0], pv));
      end
    end
    compat_mode_two <= 1'b0;
    axi_wr(5'h08, 8'hFF, 4'hF);
    check("output_reg", {24'h0, drive_output_control}, 32'hFF);
    rdchk("status_b_sel", 5'h04, 8'h20, 8'h20);
    axi_rd(5'h08);
    check("wo_read_resp", {30'h0, rsp}, 32'h2);
    check("wo_read_data", rd, 32'h0);
    master_reset_in <= 1'b1;
    @(posedge aclk);
    master_reset_in <= 1'b0;
    @(posedge aclk);
    check("output_reg_mr", {24'h0, drive_output_control}, 32'h0);
    axi_wr(5'h08, 8'h0C, 4'hF);
    for (int s = 0; s < 4; s++) begin
      axi_wr(5'h0C, {6'h3F, s[1:0]}, 4'hF);
      check("tape_resp", {30'h0, rsp}, 32'h0);
      rdchk("tape_two_bit", 5'h0C, 8'hFF, {6'h00, s[1:0]});
    end
    three_speed_enable <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      cfg_reg_f1 <= f ? 8'hC0 : 8'h30;
      repeat (4) @(posedge aclk);
      rdchk("tape_three_mode", 5'h0C, 8'hFF, f ? 8'h0F : 8'hC3);
    end
    axi_wr(5'h0C, 8'h00, 4'h0);
    rdchk("tape_no_strobe", 5'h0C, 8'hFF, 8'h0F);
    axi_wr(5'h08, 8'h0E, 4'hF);
    rdchk("tape_drive_type", 5'h0C, 8'hFF, 8'h2F);
    axi_wr(5'h14, 8'h94, 4'hF);
    rdchk("lock_on", 5'h14, 8'hFF, 8'h10);
    check("lock_flag", {31'h0, lock_flag}, 32'h1);
    axi_wr(5'h14, 8'h14, 4'hF);
    rdchk("lock_off", 5'h14, 8'hFF, 8'h00);
    axi_wr(5'h14, 8'h04, 4'hF);
    axi_wr(5'h14, 8'h05, 4'hF);
    rdchk("sense_status", 5'h14, 8'hAF, 8'h2D);
    axi_wr(5'h14, 8'h13, 4'hF);
    axi_wr(5'h14, 8'h00, 4'hF);
    axi_wr(5'h14, 8'h07, 4'hF);
    check("fifo_config", {27'h0, fifo_enable, fifo_threshold}, 32'h17);
    axi_wr(5'h14, 8'h01, 4'hF);
    rdchk("invalid_result", 5'h14, 8'hFF, 8'h80);
    check("standby", {31'h0, standby}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      axi_wr(RT_A[19-5*i -: 5], RT_D[31-8*i -: 8], 4'hF);
      check("rate_fields", {24'h0, power_down, write_shift_delay, precomp_off, rate_code,
            reduced_write_current}, {24'h0, RT_E[31-8*i -: 8]});
    end
    axi_wr(5'h10, 8'h80, 4'hF);
    repeat (2) @(posedge aclk);
    check("soft_reset_pulses", swrst_seen, 32'h1);
    axi_wr(5'h18, 8'h00, 4'hF);
    check("unmapped_write", {30'h0, rsp}, 32'h2);
    print_verdict();
  end
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
endmodule // fdcr_regs_test
bind fdcr_regs fdcr_regs_asserts u_chk (.*);
`default_nettype wire
